// ==== design/pic_irq_ctrl.sv ====
// Eight-source prioritized interrupt controller with APB register access.
// Assumes the core pulses unmask/mask/pop for one cycle and holds pc and sfr valid.
`timescale 1ns/1ps
`include "pic_irq_cfg.svh"

module pic_irq_ctrl #(
    parameter int ADDR_W = 12
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  extIrqZero,
    input  wire logic                  extIrqOne,
    input  wire logic                  keyScanIrq,
    input  wire logic                  timerZeroEvt,
    input  wire logic                  timerOneEvt,
    input  wire logic                  convDoneEvt,
    input  wire logic                  levelIndEvt,
    input  wire logic                  watchdogEvt,
    input  wire logic                  unmaskInstr,
    input  wire logic                  maskInstr,
    input  wire logic                  longWordLoad,
    input  wire logic                  retPop,
    input  wire logic [`PIC_PC_W-1:0]  pcIn,
    input  wire logic [`PIC_SFR_W-1:0] statusFlagReg,
    output logic                       acceptPulse,
    output logic                       pcLoad,
    output logic [`PIC_PC_W-1:0]       vectorPc,
    output logic                       masterMask,
    output logic [`PIC_DEPTH_W-1:0]    stackDepth,
    output logic [`PIC_PC_W-1:0]       retPc,
    output logic [`PIC_SFR_W-1:0]      retSfr,
    output logic                       lowvoltDetectOff,
    output logic                       portDriveReduce
);
    pic_irq_pkg::pic_state_reg_t r_r;
    pic_irq_pkg::pic_state_reg_t r_nxt;

    logic [`PIC_SRC_N-1:0]       srcLvl;
    logic [`PIC_SRC_N-1:0][1:0]  srcMode;
    logic [`PIC_SRC_N-1:0]       evt;
    logic [`PIC_SRC_N-1:0]       pend;
    logic [2:0]                  winIdx;
    logic                        anyPend;
    logic                        accGo;
    logic                        stkFull;
    logic                        apbAcc;
    logic                        apbDone;
    logic [7:0]                  regIdx;

    // ----------------------------------------------------------------------
    // Source edge detection
    // ----------------------------------------------------------------------
    // Bit order equals priority order, so index 0 is the top maskable source
    assign srcLvl = {watchdogEvt, levelIndEvt, keyScanIrq, convDoneEvt,
                     timerOneEvt, timerZeroEvt, extIrqOne, extIrqZero};

    always_comb
    begin
        srcMode    = {`PIC_SRC_N{`PIC_EDGE_RISE}};
        srcMode[0] = r_r.extEdge[1:0];
        srcMode[1] = r_r.extEdge[3:2];
        srcMode[5] = r_r.keyMisc[1:0];
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PIC_SRC_N; gi++)
        begin : g_edge
            pic_edge_det u_edge (
                .ref_clk (ref_clk),
                .rstn    (rstn),
                .sigIn   (srcLvl[gi]),
                .mode    (srcMode[gi]),
                .evt     (evt[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------------
    // Priority and acceptance decision
    // ----------------------------------------------------------------------
    assign pend    = r_r.flags & r_r.en;
    assign anyPend = |pend;
    assign stkFull = (r_r.depth == `PIC_DEPTH_W'(`PIC_STACK_DEPTH));

    always_comb
    begin
        winIdx = 3'h0;
        for (int i = `PIC_SRC_N - 1; i >= 0; i--)
        begin
            if (pend[i])
                winIdx = 3'(i);
        end
    end

    // Long word load holds off sampling, bounding the wait at its length
    assign accGo = (r_r.st == pic_irq_pkg::PIC_IDLE) && r_r.mask && anyPend
                   && !longWordLoad && !stkFull && !retPop;

    // ----------------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign apbAcc  = psel && penable;
    assign apbDone = apbAcc && r_r.pready;
    assign regIdx  = 8'(paddr >> 2);

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    always_comb
    begin
        logic [`PIC_SRC_N-1:0]    fl;
        logic [`PIC_DEPTH_W-1:0]  dn;
        logic [`PIC_DEPTH_W-1:0]  topI;
        logic                     hit;
        fl      = r_r.flags;
        dn      = r_r.depth;
        topI    = '0;
        hit     = 1'b0;
        r_nxt   = r_r;
        r_nxt.acc     = 1'b0;
        r_nxt.pcLoad  = 1'b0;
        r_nxt.pready  = apbAcc && !r_r.pready;
        r_nxt.pslverr = 1'b0;

        // Register access
        if (apbAcc && !r_r.pready)
        begin
            r_nxt.prdata = 32'h0;
            hit = 1'b1;
            case (regIdx)
                `PIC_IDX_REQ_LOW:  r_nxt.prdata = 32'(r_r.flags[3:0]);
                `PIC_IDX_REQ_HIGH: r_nxt.prdata = 32'(r_r.flags[7:4]);
                `PIC_IDX_EN_LOW:   r_nxt.prdata = 32'(r_r.en[3:0]);
                `PIC_IDX_EN_HIGH:  r_nxt.prdata = 32'(r_r.en[7:4]);
                `PIC_IDX_EXT_EDGE: r_nxt.prdata = 32'h0;
                `PIC_IDX_KEY_EDGE_MISC: r_nxt.prdata = 32'h0;
                default:           hit = 1'b0;
            endcase
            r_nxt.pslverr = !hit;
        end
        if (apbDone && pwrite)
        begin
            case (regIdx)
                `PIC_IDX_EXT_EDGE:      r_nxt.extEdge = pwdata[3:0];
                `PIC_IDX_KEY_EDGE_MISC: r_nxt.keyMisc = pwdata[3:0];
                `PIC_IDX_EN_LOW:        r_nxt.en[3:0] = pwdata[3:0];
                `PIC_IDX_EN_HIGH:       r_nxt.en[7:4] = pwdata[3:0];
                `PIC_IDX_REQ_LOW:       fl[3:0]       = pwdata[3:0];
                `PIC_IDX_REQ_HIGH:      fl[7:4]       = pwdata[3:0];
                default:                fl            = fl;
            endcase
        end

        // Master mask: instructions act at once, acceptance clears
        if (unmaskInstr)
            r_nxt.mask = 1'b1;
        if (maskInstr)
            r_nxt.mask = 1'b0;

        // Return from service
        if (retPop && r_r.depth != '0)
            dn = r_r.depth - `PIC_DEPTH_W'(1);

        case (r_r.st)
            pic_irq_pkg::PIC_IDLE:
            begin
                if (accGo)
                begin
                    fl[winIdx]  = 1'b0;
                    r_nxt.mask  = 1'b0;
                    r_nxt.win   = winIdx;
                    r_nxt.acc   = 1'b1;
                    r_nxt.pcStk[r_r.depth[2:0]]  = pcIn;
                    r_nxt.sfrStk[r_r.depth[2:0]] = statusFlagReg;
                    dn          = r_r.depth + `PIC_DEPTH_W'(1);
                    r_nxt.st    = pic_irq_pkg::PIC_PREP;
                end
            end
            pic_irq_pkg::PIC_PREP:
            begin
                // Single preprocessing cycle, then the vector goes out
                r_nxt.pcLoad = 1'b1;
                r_nxt.vec    = `PIC_VEC_BASE
                               + `PIC_VEC_STEP * `PIC_PC_W'(r_r.win);
                r_nxt.st     = pic_irq_pkg::PIC_VEC;
            end
            pic_irq_pkg::PIC_VEC:
            begin
                r_nxt.st = pic_irq_pkg::PIC_IDLE;
            end
            default:
            begin
                r_nxt.st = pic_irq_pkg::PIC_IDLE;
            end
        endcase

        // New edges win over any clear in the same cycle
        r_nxt.flags = fl | evt;
        r_nxt.depth = dn;
        if (dn != '0)
            topI = dn - `PIC_DEPTH_W'(1);
        r_nxt.topPc  = r_nxt.pcStk[topI[2:0]];
        r_nxt.topSfr = r_nxt.sfrStk[topI[2:0]];
    end

    // ----------------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r_r     <= '0;
            r_r.vec <= `PIC_RESET_VEC;
        end
        else
            r_r <= r_nxt;
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign prdata           = r_r.prdata;
    assign pready           = r_r.pready;
    assign pslverr          = r_r.pslverr;
    assign acceptPulse      = r_r.acc;
    assign pcLoad           = r_r.pcLoad;
    assign vectorPc         = r_r.vec;
    assign masterMask       = r_r.mask;
    assign stackDepth       = r_r.depth;
    assign retPc            = r_r.topPc;
    assign retSfr           = r_r.topSfr;
    assign lowvoltDetectOff = r_r.keyMisc[`PIC_MISC_LVD_OFF_BIT];
    assign portDriveReduce  = r_r.keyMisc[`PIC_MISC_DRIVE_BIT];

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    property p_mask_block;
        @(posedge ref_clk) disable iff (!rstn)
        !masterMask |=> !acceptPulse;
    endproperty
    a_mask_block: assert property (p_mask_block) else $error("accepted while masked");

    property p_enable_only;
        @(posedge ref_clk) disable iff (!rstn)
        accGo |-> r_r.en[winIdx] && r_r.flags[winIdx];
    endproperty
    a_enable_only: assert property (p_enable_only) else $error("disabled source won");

    property p_edge_sets;
        @(posedge ref_clk) disable iff (!rstn)
        (|evt) |=> ((r_r.flags & $past(evt)) == $past(evt));
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

    property p_flag_clear;
        @(posedge ref_clk) disable iff (!rstn)
        accGo && !evt[winIdx] |=> !r_r.flags[$past(winIdx)];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("accepted flag kept");

    property p_prep_one;
        @(posedge ref_clk) disable iff (!rstn)
        accGo |=> acceptPulse ##1 pcLoad ##1 !pcLoad;
    endproperty
    a_prep_one: assert property (p_prep_one) else $error("preprocess length wrong");

    property p_vector;
        @(posedge ref_clk) disable iff (!rstn)
        pcLoad |-> vectorPc == (16'h0002 + {12'h0, r_r.win, 1'b0});
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");

    property p_unmask_now;
        @(posedge ref_clk) disable iff (!rstn)
        unmaskInstr && !maskInstr && !accGo |=> masterMask;
    endproperty
    a_unmask_now: assert property (p_unmask_now) else $error("unmask delayed");

    property p_mask_cleared;
        @(posedge ref_clk) disable iff (!rstn)
        accGo |=> !masterMask ##1 (!masterMask || $past(unmaskInstr));
    endproperty
    a_mask_cleared: assert property (p_mask_cleared) else $error("mask not cleared");

    property p_priority;
        @(posedge ref_clk) disable iff (!rstn)
        accGo |-> (pend & ((8'h01 << winIdx) - 8'h01)) == 8'h00;
    endproperty
    a_priority: assert property (p_priority) else $error("lower priority won");

    property p_push;
        @(posedge ref_clk) disable iff (!rstn)
        accGo |=> stackDepth == $past(stackDepth) + 4'h1 && retPc == $past(pcIn);
    endproperty
    a_push: assert property (p_push) else $error("stack push wrong");

    property p_nest_limit;
        @(posedge ref_clk) disable iff (!rstn)
        stackDepth == 4'h8 |-> !accGo;
    endproperty
    a_nest_limit: assert property (p_nest_limit) else $error("stack overflow");

    property p_lwl_hold;
        @(posedge ref_clk) disable iff (!rstn)
        longWordLoad |-> !accGo;
    endproperty
    a_lwl_hold: assert property (p_lwl_hold) else $error("sampled during table read");

    c_accept: cover property (@(posedge ref_clk) disable iff (!rstn) accGo ##2 pcLoad);
    c_nested: cover property (@(posedge ref_clk) disable iff (!rstn) stackDepth == 4'h2);
    c_tie: cover property (@(posedge ref_clk) disable iff (!rstn)
        accGo && $countones(pend) > 1);
    c_flag_write: cover property (@(posedge ref_clk) disable iff (!rstn)
        apbDone && pwrite && regIdx == 8'h1c);
endmodule

// ==== design/pic_irq_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the interrupt controller.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PIC_IRQ_CFG_SVH
`define PIC_IRQ_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PIC_IDX_EXT_EDGE      8'h1a
`define PIC_IDX_KEY_EDGE_MISC 8'h1b
`define PIC_IDX_REQ_LOW       8'h1c
`define PIC_IDX_REQ_HIGH      8'h1d
`define PIC_IDX_EN_LOW        8'h1e
`define PIC_IDX_EN_HIGH       8'h1f

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define PIC_REG_W             4
`define PIC_SRC_N             8
`define PIC_RST_NIBBLE        4'h0
`define PIC_MISC_LVD_OFF_BIT  3
`define PIC_MISC_DRIVE_BIT    2
`define PIC_EDGE_NONE         2'h0
`define PIC_EDGE_FALL         2'h1
`define PIC_EDGE_RISE         2'h2
`define PIC_EDGE_BOTH         2'h3

// ----------------------------------------------------------------------
// Vectors, stacks, timing
// ----------------------------------------------------------------------
`define PIC_PC_W              16
`define PIC_SFR_W             4
`define PIC_STACK_DEPTH       8
`define PIC_DEPTH_W           4
`define PIC_RESET_VEC         16'h0000
`define PIC_VEC_BASE          16'h0002
`define PIC_VEC_STEP          16'h0002
`define PIC_PREP_CYCLES       1

`endif

// ==== design/pic_irq_pkg.sv ====
// Types shared by the interrupt controller modules.
// Assumes pic_irq_cfg.svh is on the include path.
`include "pic_irq_cfg.svh"

package pic_irq_pkg;

    typedef enum logic [1:0] {
        PIC_IDLE = 2'b00,
        PIC_PREP = 2'b01,
        PIC_VEC  = 2'b10
    } pic_state_t;

    typedef struct packed {
        logic prevLvl;
    } pic_edge_st_t;

    typedef struct packed {
        pic_state_t                                 st;
        logic [`PIC_SRC_N-1:0]                      flags;
        logic [`PIC_SRC_N-1:0]                      en;
        logic [`PIC_REG_W-1:0]                      extEdge;
        logic [`PIC_REG_W-1:0]                      keyMisc;
        logic                                       mask;
        logic [`PIC_DEPTH_W-1:0]                    depth;
        logic [`PIC_STACK_DEPTH-1:0][`PIC_PC_W-1:0] pcStk;
        logic [`PIC_STACK_DEPTH-1:0][`PIC_SFR_W-1:0] sfrStk;
        logic [2:0]                                 win;
        logic                                       acc;
        logic                                       pcLoad;
        logic [`PIC_PC_W-1:0]                       vec;
        logic [`PIC_PC_W-1:0]                       topPc;
        logic [`PIC_SFR_W-1:0]                      topSfr;
        logic [31:0]                                prdata;
        logic                                       pready;
        logic                                       pslverr;
    } pic_state_reg_t;

endpackage

// ==== design/pic_edge_det.sv ====
// Edge detector for one interrupt source, mode selects which edge counts.
// Assumes the input is synchronous to ref_clk.
`timescale 1ns/1ps
`include "pic_irq_cfg.svh"

module pic_edge_det (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       sigIn,
    input  wire logic [1:0] mode,
    output logic            evt
);
    pic_irq_pkg::pic_edge_st_t r_r;
    pic_irq_pkg::pic_edge_st_t r_nxt;

    always_comb
    begin
        r_nxt         = r_r;
        r_nxt.prevLvl = sigIn;
        case (mode)
            `PIC_EDGE_FALL: evt = r_r.prevLvl & ~sigIn;
            `PIC_EDGE_RISE: evt = ~r_r.prevLvl & sigIn;
            `PIC_EDGE_BOTH: evt = r_r.prevLvl ^ sigIn;
            default:        evt = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            r_r <= '0;
        else
            r_r <= r_nxt;
    end
endmodule

// ==== test/pic_core_model.sv ====
// Core model: moving pc and status, optional return after each vector load.
// Assumes the controller's clock and reset; commands are one-cycle pulses.
`timescale 1ns/1ps
`include "pic_irq_cfg.svh"
module pic_core_model #(
    parameter int RET_WAIT = 3
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic                  autoRet,
    input  wire logic                  pcLoad,
    input  wire logic                  cmdUnmask,
    input  wire logic                  cmdPop,
    output logic [`PIC_PC_W-1:0]       pcIn,
    output logic [`PIC_SFR_W-1:0]      statusFlagReg,
    output logic                       retPop,
    output logic                       unmaskInstr
);
    // ----------------------------------------------------------------
    // Return sequence
    // ----------------------------------------------------------------
    logic [3:0] cnt_r;
    logic       popOwn_r;
    logic       unmaskOwn_r;
    // Pc moves every cycle, so a push taken a cycle late is seen
    assign statusFlagReg = pcIn[3:0] ^ 4'ha;
    assign retPop        = popOwn_r | cmdPop;
    assign unmaskInstr   = unmaskOwn_r | cmdUnmask;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pcIn        <= 16'h0100;
            cnt_r       <= 4'h0;
            popOwn_r    <= 1'b0;
            unmaskOwn_r <= 1'b0;
        end
        else
        begin
            pcIn        <= pcIn + 16'h0003;
            popOwn_r    <= autoRet && cnt_r == 4'h1;
            unmaskOwn_r <= popOwn_r;
            if (pcLoad && autoRet)
                cnt_r <= 4'(RET_WAIT);
            else if (cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the interrupt controller.
// Assumes APB with one wait state and the core model beside the controller.
`timescale 1ns/1ps
`include "pic_irq_cfg.svh"
module tb_top;
    logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  src;
    logic        maskInstr, longWordLoad, autoRet, cmdUnmask, cmdPop, er, hung;
    logic        retPop, unmaskInstr, acceptPulse, pcLoad, masterMask, lvdOff, drvRed;
    logic [15:0] pcIn, vectorPc, retPc, pcPrev, seed, pat;
    logic [3:0]  statusFlagReg, retSfr, sfrPrev, stackDepth;
    logic [7:0]  rem;
    int          miscompares, numChecks, w;

    pic_irq_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extIrqZero(src[0]), .extIrqOne(src[1]), .timerZeroEvt(src[2]),
        .timerOneEvt(src[3]), .convDoneEvt(src[4]), .keyScanIrq(src[5]),
        .levelIndEvt(src[6]), .watchdogEvt(src[7]), .unmaskInstr(unmaskInstr),
        .maskInstr(maskInstr), .longWordLoad(longWordLoad), .retPop(retPop), .pcIn(pcIn),
        .statusFlagReg(statusFlagReg), .acceptPulse(acceptPulse), .pcLoad(pcLoad),
        .vectorPc(vectorPc), .masterMask(masterMask), .stackDepth(stackDepth),
        .retPc(retPc), .retSfr(retSfr), .lowvoltDetectOff(lvdOff), .portDriveReduce(drvRed));
    pic_core_model #(.RET_WAIT(2)) core (.ref_clk(ref_clk), .rstn(rstn), .autoRet(autoRet),
        .pcLoad(pcLoad), .cmdUnmask(cmdUnmask), .cmdPop(cmdPop), .pcIn(pcIn),
        .statusFlagReg(statusFlagReg), .retPop(retPop), .unmaskInstr(unmaskInstr));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int winner(input logic [7:0] p);
        for (int k = 0; k < 8; k++)
            if (p[k])
                return k;
        return -1;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [3:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {28'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1 && ++n < 20);
        // Slave never answered: counted, and the run is wound up
        if (n >= 20)
        begin
            chk("apbReady", 32'h0, 32'h1);
            hung = 1'b1;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 4'h0);
        chk(nm, rd, exp);
    endtask
    task automatic unmask();
        @(posedge ref_clk);
        cmdUnmask <= 1'b1;
        @(posedge ref_clk);
        cmdUnmask <= 1'b0;
        @(negedge ref_clk);
        chk("unmask", {31'h0, masterMask}, 32'h1);
    endtask
    task automatic maskOff();
        @(posedge ref_clk);
        maskInstr <= 1'b1;
        @(posedge ref_clk);
        maskInstr <= 1'b0;
        @(negedge ref_clk);
        chk("mask", {31'h0, masterMask}, 32'h0);
    endtask
    task automatic pop();
        @(posedge ref_clk);
        cmdPop <= 1'b1;
        @(posedge ref_clk);
        cmdPop <= 1'b0;
    endtask
    task automatic noAcc(input int n);
        repeat (n)
        begin
            @(negedge ref_clk);
            chk("noAccept", {31'h0, acceptPulse}, 32'h0);
        end
    endtask
    task automatic expAcc(input int i);
        int n;
        n = 0;
        do
            @(negedge ref_clk);
        while (acceptPulse !== 1'b1 && ++n < 12);
        if (n >= 12)
            hung = 1'b1;
        chk("accept", {31'h0, acceptPulse}, 32'h1);
        chk("push", {12'h0, retPc, retSfr}, {12'h0, pcPrev, sfrPrev});
        chk("maskClr", {31'h0, masterMask}, 32'h0);
        @(negedge ref_clk);
        chk("vector", {15'h0, pcLoad, vectorPc}, {16'h1, 16'h0002 + 16'(2 * i)});
    endtask

    always @(posedge ref_clk)
    begin
        pcPrev <= pcIn;
        sfrPrev <= statusFlagReg;
    end
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        for (int t = 0; t < 60000 && hung !== 1'b1; t++)
            @(posedge ref_clk);
        miscompares++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rstn, psel, penable, pwrite, maskInstr, longWordLoad, autoRet, hung} = 8'h0;
        {cmdUnmask, cmdPop, paddr, pwdata, src} = 54'h0;
        miscompares = 0;
        numChecks = 0;
        seed = 16'h47f7;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        chk("resetVec", {16'h0, vectorPc}, 32'h0);
        for (int k = 0; k < 6; k++)
            rdc("resetVal", `PIC_IDX_EXT_EDGE + 8'(k), 32'h0);
        apb(1'b1, 8'h10, 4'hf);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        apb(1'b1, `PIC_IDX_KEY_EDGE_MISC, 4'hc);
        @(negedge ref_clk);
        chk("misc", {30'h0, lvdOff, drvRed}, 32'h3);
        apb(1'b1, `PIC_IDX_KEY_EDGE_MISC, 4'h2);
        @(negedge ref_clk);
        chk("misc", {30'h0, lvdOff, drvRed}, 32'h0);
        rdc("writeOnly", `PIC_IDX_KEY_EDGE_MISC, 32'h0);
        // Every source alone, core returns and re-arms by itself
        apb(1'b1, `PIC_IDX_EN_LOW, 4'hf);
        apb(1'b1, `PIC_IDX_EN_HIGH, 4'hf);
        apb(1'b1, `PIC_IDX_EXT_EDGE, 4'ha);
        autoRet <= 1'b1;
        unmask();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            src[i] <= 1'b1;
            expAcc(i);
            @(posedge ref_clk);
            src[i] <= 1'b0;
            rdc("accClr", `PIC_IDX_REQ_LOW + 8'(i / 4), 32'h0);
            for (int n = 0; n < 20 && masterMask !== 1'b1; n++)
                @(negedge ref_clk);
            if (masterMask !== 1'b1)
                hung = 1'b1;
            chk("reArm", {31'h0, masterMask}, 32'h1);
        end
        // Edge modes on both external pins and the key input
        apb(1'b1, `PIC_IDX_EN_LOW, 4'h0);
        apb(1'b1, `PIC_IDX_EN_HIGH, 4'h0);
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, `PIC_IDX_EXT_EDGE, 4'(m * 5));
            apb(1'b1, `PIC_IDX_KEY_EDGE_MISC, 4'(m));
            apb(1'b1, `PIC_IDX_REQ_LOW, 4'h0);
            apb(1'b1, `PIC_IDX_REQ_HIGH, 4'h0);
            @(posedge ref_clk);
            src <= 8'h23;
            rdc("rise", `PIC_IDX_REQ_LOW, {30'h0, m[1], m[1]});
            rdc("riseKey", `PIC_IDX_REQ_HIGH, {30'h0, m[1], 1'b0});
            apb(1'b1, `PIC_IDX_REQ_LOW, 4'h0);
            apb(1'b1, `PIC_IDX_REQ_HIGH, 4'h0);
            rdc("levelHeld", `PIC_IDX_REQ_LOW, 32'h0);
            @(posedge ref_clk);
            src <= 8'h00;
            rdc("fall", `PIC_IDX_REQ_LOW, {30'h0, m[0], m[0]});
            rdc("fallKey", `PIC_IDX_REQ_HIGH, {30'h0, m[0], 1'b0});
        end
        // Random flag and enable sets: priority, masking, table-read stall
        autoRet <= 1'b0;
        for (int r = 0; r < 8; r++)
        begin
            maskOff();
            seed = lfsr(lfsr(seed));
            pat = (r == 0) ? 16'hffff : (r == 1) ? 16'h8080 : seed;
            apb(1'b1, `PIC_IDX_REQ_LOW, pat[3:0]);
            apb(1'b1, `PIC_IDX_REQ_HIGH, pat[7:4]);
            apb(1'b1, `PIC_IDX_EN_LOW, pat[11:8]);
            apb(1'b1, `PIC_IDX_EN_HIGH, pat[15:12]);
            rdc("flagLo", `PIC_IDX_REQ_LOW, {28'h0, pat[3:0]});
            rdc("flagHi", `PIC_IDX_REQ_HIGH, {28'h0, pat[7:4]});
            rdc("enLo", `PIC_IDX_EN_LOW, {28'h0, pat[11:8]});
            rdc("enHi", `PIC_IDX_EN_HIGH, {28'h0, pat[15:12]});
            longWordLoad <= (r == 0);
            noAcc(3);
            unmask();
            if (r == 0)
            begin
                noAcc(3);
                @(posedge ref_clk);
                longWordLoad <= 1'b0;
            end
            w = winner(pat[7:0] & pat[15:8]);
            if (w < 0)
                noAcc(4);
            else
            begin
                expAcc(w);
                rem = pat[7:0] & ~(8'h01 << w);
                rdc("leftLo", `PIC_IDX_REQ_LOW, {28'h0, rem[3:0]});
                rdc("leftHi", `PIC_IDX_REQ_HIGH, {28'h0, rem[7:4]});
                pop();
            end
        end
        // Nesting until both stacks are full
        maskOff();
        apb(1'b1, `PIC_IDX_EN_LOW, 4'h1);
        apb(1'b1, `PIC_IDX_EN_HIGH, 4'h0);
        for (int k = 0; k < 9; k++)
        begin
            apb(1'b1, `PIC_IDX_REQ_LOW, 4'h1);
            unmask();
            if (k < 8)
                expAcc(0);
            else
                noAcc(4);
        end
        chk("depthFull", {28'h0, stackDepth}, 32'h8);
        maskOff();
        repeat (8) pop();
        @(negedge ref_clk);
        chk("depthEmpty", {28'h0, stackDepth}, 32'h0);
        conclude();
    end
endmodule
